/* File: efss_pkg.sv */
package efss_pkg;
   // Setting word widths (fixed point, hundredths)
   localparam int EFSS_VW = 16;
   // Parameter indices on the setting port
   localparam logic [3:0] EFSS_P_LOW_START = 4'h0;
   localparam logic [3:0] EFSS_P_LOW_DELAY = 4'h1;
   localparam logic [3:0] EFSS_P_MULT = 4'h2;
   localparam logic [3:0] EFSS_P_HIGH_START = 4'h3;
   localparam logic [3:0] EFSS_P_HIGH_DELAY = 4'h4;
   localparam logic [3:0] EFSS_P_SWITCH_ONE = 4'h5;
   localparam logic [3:0] EFSS_P_HIGH_OFF = 4'h6;
   localparam logic [3:0] EFSS_P_INVERSE = 4'h7;
   localparam logic [3:0] EFSS_P_GROUP_CFG = 4'h8;
   // Defaults in hundredths
   localparam logic [15:0] EFSS_LOW_START_RST = 16'h0001;
   localparam logic [15:0] EFSS_LOW_DELAY_RST = 16'h0005;
   localparam logic [15:0] EFSS_MULT_RST = 16'h0005;
   localparam logic [15:0] EFSS_HIGH_START_RST = 16'h0005;
   localparam logic [15:0] EFSS_HIGH_DELAY_RST = 16'h0004;
   localparam logic [7:0] EFSS_SW1_RST = 8'h00;
   // Inverse-time clamp of low-set start, 0.40 x In
   localparam logic [15:0] EFSS_INV_CLAMP = 16'h0028;
   // Read value when high-set stage is out of operation
   localparam logic [15:0] EFSS_HIGH_OFF_VAL = 16'h03E7;
   // Switch positions inside function_switch_group_one
   localparam int EFSS_SW_LATCH1 = 0;
   localparam int EFSS_SW_LATCH2 = 1;
   localparam int EFSS_SW_SIG_PULSE = 2;
   localparam int EFSS_SW_PWR_PULSE = 3;
   // Pulse timing
   localparam int EFSS_CLK_MHZ = 50;
   localparam int EFSS_PULSE_LONG_MS = 80;
   localparam int EFSS_PULSE_SHORT_MS = 40;
   localparam int EFSS_LONG_CYC = EFSS_PULSE_LONG_MS * 1000 * EFSS_CLK_MHZ;
   localparam int EFSS_SHORT_CYC = EFSS_PULSE_SHORT_MS * 1000 * EFSS_CLK_MHZ;
   localparam int EFSS_CW = 22;
   typedef enum logic [1:0] {EFSS_IDLE, EFSS_HOLD, EFSS_LATCH} efss_out_t;
endpackage

/* File: efss_group.sv */
`timescale 1ns/1ns
// One complete setting group with its own storage
module efss_group
   import efss_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic we_i,
   input wire logic [3:0] idx_i,
   input wire logic [15:0] data_i,
   output logic [15:0] low_start_o,
   output logic [15:0] low_delay_o,
   output logic [15:0] mult_o,
   output logic [15:0] high_start_o,
   output logic [15:0] high_delay_o,
   output logic [7:0] sw_one_o,
   output logic high_off_o,
   output logic inverse_o
);
   typedef struct packed {
      logic [15:0] low_start;
      logic [15:0] low_delay;
      logic [15:0] mult;
      logic [15:0] high_start;
      logic [15:0] high_delay;
      logic [7:0] sw_one;
      logic high_off;
      logic inverse;
   } efss_grp_t;
   efss_grp_t s_q, s_d;

   // Store one word at the addressed setting
   always_comb begin
      s_d = s_q;
      if (we_i) begin
         unique case (idx_i)
            EFSS_P_LOW_START: s_d.low_start = data_i;
            EFSS_P_LOW_DELAY: s_d.low_delay = data_i;
            EFSS_P_MULT: s_d.mult = data_i;
            EFSS_P_HIGH_START: s_d.high_start = data_i;
            EFSS_P_HIGH_DELAY: s_d.high_delay = data_i;
            EFSS_P_SWITCH_ONE: s_d.sw_one = data_i[7:0];
            EFSS_P_HIGH_OFF: s_d.high_off = data_i[0];
            EFSS_P_INVERSE: s_d.inverse = data_i[0];
            default: s_d = s_q; // Unknown index ignored
         endcase
      end
   end

   // Register with defaults
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q.low_start <= EFSS_LOW_START_RST;
         s_q.low_delay <= EFSS_LOW_DELAY_RST;
         s_q.mult <= EFSS_MULT_RST;
         s_q.high_start <= EFSS_HIGH_START_RST;
         s_q.high_delay <= EFSS_HIGH_DELAY_RST;
         s_q.sw_one <= EFSS_SW1_RST;
         s_q.high_off <= 1'b0;
         s_q.inverse <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign low_start_o = s_q.low_start;
   assign low_delay_o = s_q.low_delay;
   assign mult_o = s_q.mult;
   assign high_start_o = s_q.high_start;
   assign high_delay_o = s_q.high_delay;
   assign sw_one_o = s_q.sw_one;
   assign high_off_o = s_q.high_off;
   assign inverse_o = s_q.inverse;
endmodule

/* File: efss_pulse.sv */
`timescale 1ns/1ns
// Output stretcher with optional latch and minimum pulse length
module efss_pulse
   import efss_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic trip_i,
   input wire logic latch_en_i,
   input wire logic short_i,
   input wire logic release_i,
   output logic out_o
);
   typedef struct packed {
      efss_out_t st;
      logic [EFSS_CW-1:0] cnt;
      logic out;
   } efss_pst_t;
   efss_pst_t s_q, s_d;

   // Minimum pulse then follow trip, or latch
   always_comb begin
      s_d = s_q;
      unique case (s_q.st)
         EFSS_IDLE: begin
            if (trip_i) begin
               s_d.out = 1'b1;
               s_d.st = EFSS_HOLD;
               s_d.cnt = short_i ? EFSS_CW'(EFSS_SHORT_CYC - 1)
                                 : EFSS_CW'(EFSS_LONG_CYC - 1);
            end
         end
         EFSS_HOLD: begin
            if (s_q.cnt != '0) begin
               s_d.cnt = s_q.cnt - 1'b1;
            end
            if (latch_en_i) begin
               s_d.st = EFSS_LATCH;
            end else if (s_q.cnt == '0 && !trip_i) begin
               s_d.out = 1'b0;
               s_d.st = EFSS_IDLE;
            end
         end
         EFSS_LATCH: begin
            // Latch overrides minimum pulse length
            if (release_i && !trip_i) begin
               s_d.out = 1'b0;
               s_d.st = EFSS_IDLE;
               s_d.cnt = '0;
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q.st <= EFSS_IDLE;
         s_q.cnt <= '0;
         s_q.out <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign out_o = s_q.out;
endmodule

/* File: efss_store.sv */
`timescale 1ns/1ns
// What this block does
// - two groups, one applied at once
// - configure groups locally or by parameter
// - binary input chooses active group
// - low-set start stored, default 0.01
// - inverse-time low-set start clamped to 0.40 at low_start_o, host read unclamped
// - low-set delay stored, default 0.05 s
// - time multiplier stored, default 0.05
// - high-set start stored, default 0.05
// - high-set delay stored, default 0.04 s
// - high-set off reads back 999
// - switches settable, checksum is weighted sum
// - unlatched power output follows signal drop
// - latched power output stays active
// - panel, input or bus releases latch
// - switch three sets signal pulse length
// - first switchgroup resets to zero
// - switch four sets power pulse length
module efss_store
   import efss_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   // Local panel setting port
   input wire logic panel_we_i,
   input wire logic panel_grp_i,
   input wire logic [3:0] panel_idx_i,
   input wire logic [15:0] panel_data_i,
   input wire logic panel_release_i,
   // Serial host setting port
   input wire logic host_we_i,
   input wire logic [3:0] host_idx_i,
   input wire logic [15:0] host_data_i,
   input wire logic host_release_i,
   input wire logic [3:0] host_rd_idx_i,
   output logic [15:0] host_rd_data_o,
   // External binary inputs (pins)
   input wire logic group_sel_pin_i,
   input wire logic release_pin_i,
   // Trip requests from protection logic
   input wire logic trip_one_i,
   input wire logic trip_two_i,
   input wire logic sig_one_i,
   input wire logic sig_two_i,
   // Active settings
   output logic active_group_o,
   output logic [15:0] low_start_o,
   output logic [15:0] low_delay_o,
   output logic [15:0] mult_o,
   output logic [15:0] high_start_o,
   output logic [15:0] high_delay_o,
   output logic high_enable_o,
   output logic [7:0] switch_one_o,
   output logic [7:0] checksum_o,
   output logic power_output_one_o,
   output logic power_output_two_o,
   output logic signal_output_one_o,
   output logic signal_output_two_o
);
   typedef struct packed {
      logic [1:0] sel_sync;
      logic [1:0] rel_sync;
      logic host_grp;
      logic [15:0] rd_data;
   } efss_top_t;
   efss_top_t s_q, s_d;

   // Per-group write signals
   logic we_g[2];
   logic [3:0] idx_g;
   logic [15:0] data_g;
   logic [15:0] lo_s[2], lo_d[2], mu[2], hi_s[2], hi_d[2];
   logic [7:0] sw[2];
   logic hi_off[2], inv[2];
   logic act; // Active group index
   logic [7:0] sw_act;
   logic [15:0] lo_eff; // Low start after clamp
   logic [15:0] hi_rd; // High start as read by host
   logic release_any;

   // Panel has priority over the host on a collision
   always_comb begin
      idx_g = panel_we_i ? panel_idx_i : host_idx_i;
      data_g = panel_we_i ? panel_data_i : host_data_i;
      for (int g = 0; g < 2; g++) begin
         we_g[g] = panel_we_i ? (panel_grp_i == g[0])
                 : (host_we_i && host_idx_i != EFSS_P_GROUP_CFG
                    && s_q.host_grp == g[0]);
      end
   end

   // Two groups of storage
   for (genvar g = 0; g < 2; g++) begin : g_grp
      efss_group u_grp (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .we_i(we_g[g]),
         .idx_i(idx_g),
         .data_i(data_g),
         .low_start_o(lo_s[g]),
         .low_delay_o(lo_d[g]),
         .mult_o(mu[g]),
         .high_start_o(hi_s[g]),
         .high_delay_o(hi_d[g]),
         .sw_one_o(sw[g]),
         .high_off_o(hi_off[g]),
         .inverse_o(inv[g])
      );
   end

   // Active selection from synchronised binary input
   always_comb begin
      act = s_q.sel_sync[1];
      sw_act = sw[act];
      lo_eff = lo_s[act];
      if (inv[act] && lo_s[act] > EFSS_INV_CLAMP) begin
         lo_eff = EFSS_INV_CLAMP;
      end
      hi_rd = hi_off[act] ? EFSS_HIGH_OFF_VAL : hi_s[act];
      release_any = panel_release_i || host_release_i
                  || s_q.rel_sync[1];
   end

   // Synchronisers, group parameter and host readback
   always_comb begin
      s_d = s_q;
      s_d.sel_sync = {s_q.sel_sync[0], group_sel_pin_i};
      s_d.rel_sync = {s_q.rel_sync[0], release_pin_i};
      if (host_we_i && !panel_we_i && host_idx_i == EFSS_P_GROUP_CFG) begin
         s_d.host_grp = host_data_i[0];
      end
      unique case (host_rd_idx_i)
         EFSS_P_LOW_START: s_d.rd_data = lo_s[act];
         EFSS_P_LOW_DELAY: s_d.rd_data = lo_d[act];
         EFSS_P_MULT: s_d.rd_data = mu[act];
         EFSS_P_HIGH_START: s_d.rd_data = hi_rd;
         EFSS_P_HIGH_DELAY: s_d.rd_data = hi_d[act];
         EFSS_P_SWITCH_ONE: s_d.rd_data = {8'h00, sw_act};
         EFSS_P_HIGH_OFF: s_d.rd_data = {15'h0000, hi_off[act]};
         EFSS_P_INVERSE: s_d.rd_data = {15'h0000, inv[act]};
         EFSS_P_GROUP_CFG: s_d.rd_data = {15'h0000, s_q.host_grp};
         default: s_d.rd_data = 16'h0000;
      endcase
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q.sel_sync <= 2'h0;
         s_q.rel_sync <= 2'h0;
         s_q.host_grp <= 1'b0;
         s_q.rd_data <= 16'h0000;
      end else begin
         s_q <= s_d;
      end
   end

   // Power outputs: latch switch and power pulse switch
   efss_pulse u_po1 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .trip_i(trip_one_i),
      .latch_en_i(sw_act[EFSS_SW_LATCH1]),
      .short_i(sw_act[EFSS_SW_PWR_PULSE]),
      .release_i(release_any),
      .out_o(power_output_one_o)
   );
   efss_pulse u_po2 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .trip_i(trip_two_i),
      .latch_en_i(sw_act[EFSS_SW_LATCH2]),
      .short_i(sw_act[EFSS_SW_PWR_PULSE]),
      .release_i(release_any),
      .out_o(power_output_two_o)
   );
   // Signal outputs: never latch, switch three length
   efss_pulse u_so1 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .trip_i(sig_one_i),
      .latch_en_i(1'b0),
      .short_i(sw_act[EFSS_SW_SIG_PULSE]),
      .release_i(1'b0),
      .out_o(signal_output_one_o)
   );
   efss_pulse u_so2 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .trip_i(sig_two_i),
      .latch_en_i(1'b0),
      .short_i(sw_act[EFSS_SW_SIG_PULSE]),
      .release_i(1'b0),
      .out_o(signal_output_two_o)
   );

   // Active setting outputs
   assign active_group_o = act;
   assign low_start_o = lo_eff;
   assign low_delay_o = lo_d[act];
   assign mult_o = mu[act];
   assign high_start_o = hi_rd;
   assign high_delay_o = hi_d[act];
   assign high_enable_o = !hi_off[act];
   assign switch_one_o = sw_act;
   // Weighted sum of set switches equals the packed byte
   assign checksum_o = sw_act;
   assign host_rd_data_o = s_q.rd_data;
endmodule

/* File: efss_chk.sv */
`timescale 1ns/1ns
// Port-level checks of the setting store
module efss_chk
   import efss_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] host_rd_idx_i,
   input wire logic [15:0] host_rd_data_o,
   input wire logic group_sel_pin_i,
   input wire logic trip_one_i,
   input wire logic sig_one_i,
   input wire logic active_group_o,
   input wire logic [15:0] low_start_o,
   input wire logic [15:0] low_delay_o,
   input wire logic [15:0] high_start_o,
   input wire logic high_enable_o,
   input wire logic [7:0] switch_one_o,
   input wire logic [7:0] checksum_o,
   input wire logic power_output_one_o,
   input wire logic signal_output_one_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Defaults right after reset
   dflt_values_a: assert property ($fell(rst_i) |->
      low_start_o == EFSS_LOW_START_RST && low_delay_o == EFSS_LOW_DELAY_RST
      && high_start_o == EFSS_HIGH_START_RST && switch_one_o == EFSS_SW1_RST)
      else $error("defaults wrong after reset");
   checksum_sum_a: assert property (checksum_o == switch_one_o)
      else $error("checksum differs from switch byte");
   high_off_read_a: assert property (!high_enable_o |->
      high_start_o == EFSS_HIGH_OFF_VAL) else $error("high off not 999");
   // Host read shows the applied group
   read_active_a: assert property (host_rd_idx_i == EFSS_P_LOW_DELAY
      ##1 $stable(low_delay_o) |-> host_rd_data_o == low_delay_o)
      else $error("host read not from active group");
   group_follow_a: assert property ($stable(group_sel_pin_i)[*4] |->
      active_group_o == group_sel_pin_i) else $error("group not following");
   power_take_a: assert property (trip_one_i && !power_output_one_o
      |=> power_output_one_o) else $error("power request not taken");
   power_hold_a: assert property (power_output_one_o && trip_one_i
      |=> power_output_one_o) else $error("power output dropped early");
   power_min_a: assert property ($rose(power_output_one_o) |->
      power_output_one_o[*8]) else $error("power pulse too short");
   power_cause_a: assert property ($rose(power_output_one_o) |->
      $past(trip_one_i)) else $error("power output without request");
   sig_take_a: assert property (sig_one_i && !signal_output_one_o
      |=> signal_output_one_o[*4]) else $error("signal pulse too short");
endmodule

bind efss_store efss_chk chk (.clk_i(clk_i), .rst_i(rst_i),
   .host_rd_idx_i(host_rd_idx_i), .host_rd_data_o(host_rd_data_o),
   .group_sel_pin_i(group_sel_pin_i), .trip_one_i(trip_one_i),
   .sig_one_i(sig_one_i), .active_group_o(active_group_o),
   .low_start_o(low_start_o), .low_delay_o(low_delay_o),
   .high_start_o(high_start_o), .high_enable_o(high_enable_o),
   .switch_one_o(switch_one_o), .checksum_o(checksum_o),
   .power_output_one_o(power_output_one_o),
   .signal_output_one_o(signal_output_one_o));

/* File: efss_host.sv */
`timescale 1ns/1ns
// Serial host model: parameter writes and reads
module efss_host
   import efss_pkg::*;
(
   input wire logic clk_i,
   input wire logic [15:0] rd_data_i,
   output logic we_o,
   output logic [3:0] idx_o,
   output logic [15:0] data_o,
   output logic [3:0] rd_idx_o,
   output logic release_o
);
   // Idle bus at time zero
   initial begin
      we_o = 1'b0;
      idx_o = 4'hF;
      data_o = 16'h0000;
      rd_idx_o = 4'hF;
      release_o = 1'b0;
   end
   // One-cycle strobe; released data no longer shows the word
   task automatic write(input logic [3:0] idx, input logic [15:0] data);
      @(posedge clk_i);
      we_o <= 1'b1;
      idx_o <= idx;
      data_o <= data;
      @(posedge clk_i);
      we_o <= 1'b0;
      data_o <= ~data;
   endtask
   // Index taken at an edge, word valid the cycle after
   task automatic read(input logic [3:0] idx, output logic [15:0] data);
      @(posedge clk_i);
      rd_idx_o <= idx;
      @(posedge clk_i);
      @(negedge clk_i);
      data = rd_data_i;
   endtask
endmodule

/* File: efss_store_test.sv */
`timescale 1ns/1ns
// Bench: panel and pins driven here, serial side by the host model
module efss_store_test;
   import efss_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic p_we = 1'b0, p_grp = 1'b0, p_rel = 1'b0, pin_g = 1'b0, pin_r = 1'b0;
   logic [3:0] p_idx = 4'h0;
   logic [15:0] p_dat = 16'h0000;
   logic [1:0] trip = 2'h0, sig = 2'h0;
   logic h_we, h_rel, grp, hen;
   logic [3:0] h_idx, h_ri, outs;
   logic [15:0] h_dat, h_rd, ls, ld, mu, hs, hd, rd;
   logic [7:0] sw, cs;
   int failures = 0, compares = 0;

   initial forever #10 clk_i = ~clk_i;

   efss_host host (.clk_i(clk_i), .rd_data_i(h_rd), .we_o(h_we),
      .idx_o(h_idx), .data_o(h_dat), .rd_idx_o(h_ri), .release_o(h_rel));

   efss_store dut (.clk_i(clk_i), .rst_i(rst_i), .panel_we_i(p_we),
      .panel_grp_i(p_grp), .panel_idx_i(p_idx), .panel_data_i(p_dat),
      .panel_release_i(p_rel), .host_we_i(h_we), .host_idx_i(h_idx),
      .host_data_i(h_dat), .host_release_i(h_rel), .host_rd_idx_i(h_ri),
      .host_rd_data_o(h_rd), .group_sel_pin_i(pin_g),
      .release_pin_i(pin_r), .trip_one_i(trip[1]), .trip_two_i(trip[0]),
      .sig_one_i(sig[1]), .sig_two_i(sig[0]), .active_group_o(grp),
      .low_start_o(ls), .low_delay_o(ld), .mult_o(mu), .high_start_o(hs),
      .high_delay_o(hd), .high_enable_o(hen), .switch_one_o(sw),
      .checksum_o(cs), .power_output_one_o(outs[3]),
      .power_output_two_o(outs[2]), .signal_output_one_o(outs[1]),
      .signal_output_two_o(outs[0]));

   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Verdict and end of run
   task automatic complete_run();
      if (failures == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Panel write, one-cycle strobe
   task automatic pwr(input logic g, input logic [3:0] i, input logic [15:0] d);
      @(posedge clk_i);
      p_we <= 1'b1;
      p_grp <= g;
      p_idx <= i;
      p_dat <= d;
      @(posedge clk_i);
      p_we <= 1'b0;
      p_dat <= ~d;
   endtask
   // Host write, then look once the value has landed
   task automatic hw(input logic [3:0] i, input logic [15:0] d);
      host.write(i, d);
      @(negedge clk_i);
   endtask
   // Reset for three cycles
   task automatic do_reset();
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
   endtask

   // Hang guard
   initial begin
      repeat (100000) @(posedge clk_i);
      failures++;
      complete_run();
   end

   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      check(ls, EFSS_LOW_START_RST);
      check(ld, EFSS_LOW_DELAY_RST);
      check(hd, EFSS_HIGH_DELAY_RST);
      check({8'h00, cs}, 16'h0000);
      host.read(EFSS_P_MULT, rd);
      check(rd, EFSS_MULT_RST);
      host.read(EFSS_P_HIGH_START, rd);
      check(rd, EFSS_HIGH_START_RST);
      host.read(EFSS_P_LOW_DELAY, rd);
      check(rd, EFSS_LOW_DELAY_RST);
      // Low-set start, definite then inverse-time clamp
      hw(EFSS_P_LOW_START, 16'h0050);
      check(ls, 16'h0050);
      hw(EFSS_P_INVERSE, 16'h0001);
      check(ls, 16'h0028);
      hw(EFSS_P_LOW_START, 16'h0027);
      check(ls, 16'h0027);
      hw(EFSS_P_INVERSE, 16'h0000);
      // Each switch alone, then a mixed pattern
      for (int i = 0; i < 8; i++) begin
         hw(EFSS_P_SWITCH_ONE, 16'h0001 << i);
         check({8'h00, cs}, 16'h0001 << i);
      end
      hw(EFSS_P_SWITCH_ONE, 16'h0055);
      check({8'h00, cs}, 16'h0055);
      // High-set stage out of operation
      hw(EFSS_P_HIGH_OFF, 16'h0001);
      check({15'h0000, hen}, 16'h0000);
      host.read(EFSS_P_HIGH_START, rd);
      check(rd, EFSS_HIGH_OFF_VAL);
      hw(EFSS_P_HIGH_OFF, 16'h0000);
      check(hs, EFSS_HIGH_START_RST);
      // Second group filled by host and panel, collision drops host
      hw(EFSS_P_GROUP_CFG, 16'h0001);
      hw(EFSS_P_LOW_DELAY, 16'h0077);
      check(ld, EFSS_LOW_DELAY_RST);
      fork
         host.write(EFSS_P_MULT, 16'h0011);
         pwr(1'b0, EFSS_P_MULT, 16'h0022);
      join
      pwr(1'b1, EFSS_P_HIGH_DELAY, 16'h0099);
      @(negedge clk_i);
      check(mu, 16'h0022);
      @(posedge clk_i);
      pin_g <= 1'b1;
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      check({15'h0000, grp}, 16'h0001);
      check(ld, 16'h0077);
      check(hd, 16'h0099);
      check(mu, EFSS_MULT_RST);
      check(ls, EFSS_LOW_START_RST);
      @(posedge clk_i);
      pin_g <= 1'b0;
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      check(ls, 16'h0027);
      // Outputs: taken, releases refused, held past request drop
      @(posedge clk_i);
      trip <= 2'h3;
      sig <= 2'h3;
      @(posedge clk_i);
      @(negedge clk_i);
      check({12'h000, outs}, 16'h000F);
      @(posedge clk_i);
      pin_r <= 1'b1;
      p_rel <= 1'b1;
      repeat (5) @(posedge clk_i);
      pin_r <= 1'b0;
      p_rel <= 1'b0;
      // Let the synchronised pin release drain before the request drops
      repeat (4) @(posedge clk_i);
      trip <= 2'h0;
      sig <= 2'h0;
      repeat (10) @(posedge clk_i);
      @(negedge clk_i);
      check({12'h000, outs}, 16'h000F);
      // Panel release frees the latched output only
      @(posedge clk_i);
      p_rel <= 1'b1;
      @(posedge clk_i);
      p_rel <= 1'b0;
      @(negedge clk_i);
      check({12'h000, outs}, 16'h0007);
      // Reset in mid-run restores everything
      do_reset();
      check({12'h000, outs}, 16'h0000);
      check({8'h00, sw}, 16'h0000);
      check(ls, EFSS_LOW_START_RST);
      complete_run();
   end
endmodule
